//--- hdl/sfp_pkg.sv
// Shared constants, opcodes and address helpers for the serial flash program link
// Assumes both ends agree on page size through their own page-size inputs
package sfp_pkg;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_BUF1_WRITE      = 8'h84;
   localparam logic [7:0] OP_BUF2_WRITE      = 8'h87;
   localparam logic [7:0] OP_BUF1_EPROG      = 8'h83;
   localparam logic [7:0] OP_BUF2_EPROG      = 8'h86;
   localparam logic [7:0] OP_BUF1_PROG       = 8'h88;
   localparam logic [7:0] OP_BUF2_PROG       = 8'h89;
   localparam logic [7:0] OP_BUF1_LOAD_EPROG = 8'h82;
   localparam logic [7:0] OP_BUF2_LOAD_EPROG = 8'h85;
   localparam logic [7:0] OP_BYTE_PROG       = 8'h02;

   // ----------------------------------------------------------------
   // Address layout
   // ----------------------------------------------------------------
   localparam int         PAGE_W        = 11;
   localparam int         OFF_W         = 9;
   localparam int         ADDR_W        = 24;
   localparam int         STD_PAGE_LSB  = 9;
   localparam int         BIN_PAGE_LSB  = 8;
   localparam int         BIN_OFF_W     = 8;
   localparam int         BUF_BYTES     = 264;
   localparam logic [8:0] STD_LAST      = 9'h107;
   localparam logic [8:0] BIN_LAST      = 9'h0ff;
   localparam logic [2:0] HDR_BYTES     = 3'h4;
   localparam logic [2:0] LAST_BIT      = 3'h7;
   localparam logic [7:0] ERASED_BYTE   = 8'hff;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS               = 10;
   localparam int PER_BYTE_PROGRAM_TIME_NS    = 100;
   localparam int ERASE_STEP_TIME_NS          = 20;
   localparam int SCK_HALF_NS                 = 80;
   // Program and erase times round down, never below one cycle
   localparam int BYTE_PROG_CYC  = (PER_BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   PER_BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
   localparam int ERASE_STEP_CYC = (ERASE_STEP_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   ERASE_STEP_TIME_NS / CLK_PERIOD_NS;
   localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a, input logic bin);
      page_of = bin ? a[BIN_PAGE_LSB +: PAGE_W] : a[STD_PAGE_LSB +: PAGE_W];
   endfunction

   function automatic logic [OFF_W-1:0] offset_of(input logic [ADDR_W-1:0] a, input logic bin);
      offset_of = bin ? {1'b0, a[BIN_OFF_W-1:0]} : a[OFF_W-1:0];
   endfunction

   function automatic logic [OFF_W-1:0] page_last(input logic bin);
      page_last = bin ? BIN_LAST : STD_LAST;
   endfunction

   function automatic logic [OFF_W-1:0] wrap_inc(input logic [OFF_W-1:0] o, input logic bin);
      wrap_inc = (o >= page_last(bin)) ? '0 : o + 9'h001;
   endfunction

   function automatic logic [ADDR_W-1:0] build_addr(input logic [PAGE_W-1:0] p,
                                                    input logic [OFF_W-1:0] o,
                                                    input logic bin);
      build_addr = bin ? {5'h00, p, o[BIN_OFF_W-1:0]} : {4'h0, p, o};
   endfunction

endpackage

//--- hdl/sfp_if.sv
// Serial link between the program-command host and the flash device
// Assumes the host drives every wire; the device only listens
`timescale 1ns/1ps
interface sfp_if;
   logic cs_n;
   logic sck;
   logic si;
   modport dev  (input  cs_n, input  sck, input  si);
   modport host (output cs_n, output sck, output si);
endinterface

//--- hdl/sfp_sync.sv
// Three-stage input synchroniser with agreement filter
// Assumes d comes from outside the clk domain
`timescale 1ns/1ps
module sfp_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic d,
   output logic      q
);
   logic [2:0] ff;
   logic       next_q;

   // Stage one feeds stage two only; a change counts once two and three agree
   always_comb begin
      next_q = (ff[1] == ff[2]) ? ff[2] : q;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ff <= {3{INIT}};
         q  <= INIT;
      end else begin
         ff <= {ff[1:0], d};
         q  <= next_q;
      end
   end
endmodule

//--- hdl/sfp_device.sv
// Flash device end: command decode, two page buffers, self-timed erase/program
// Assumes the main array sits outside on the array port with combinational read data
`timescale 1ns/1ps
// Behaviour
// - Standard buffer write: 84h/87h, nine-bit offset
// - Binary buffer write: eight-bit offset after sixteen
// - Data bytes fill buffer, wrapping, until deselect
// - Standard erase-program 83h/86h carries page number
// - Binary erase-program page on upper address bits
// - Deselect erases page then programs buffer, busy
// - Failed byte verify sets error flag
// - Standard program-only 88h/89h carries page number
// - Binary program-only page on upper address bits
// - Deselect programs buffer into page, busy shown
// - Standard load-erase-program 82h/85h with offset
// - Binary load-erase-program page plus offset
// - Load bytes, then erase and program, busy
// - Byte program 02h through buffer one
// - Binary byte program uses 19-bit logical address
// - Only received byte locations get programmed
// - Partial final byte aborts byte program
// - Byte program time scales with byte count
module sfp_device
   import sfp_pkg::*;
#(
   parameter int BYTE_PROG_CYCLES  = BYTE_PROG_CYC,
   parameter int ERASE_STEP_CYCLES = ERASE_STEP_CYC
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   sfp_if.dev                     link,
   input  wire logic              binary_page_size,
   output logic                   busy,
   output logic                   erase_program_error_flag,
   output logic                   array_we,
   output logic [PAGE_W-1:0]      array_page,
   output logic [OFF_W-1:0]       array_offset,
   output logic [7:0]             array_wdata,
   input  wire logic [7:0]        array_rdata
);
   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   logic cs_q, sck_q, si_q, cs_d, sck_d;

   sfp_sync #(.INIT(1'b1)) u_cs  (.clk(clk), .nrst(nrst), .d(link.cs_n), .q(cs_q));
   sfp_sync #(.INIT(1'b0)) u_sck (.clk(clk), .nrst(nrst), .d(link.sck),  .q(sck_q));
   sfp_sync #(.INIT(1'b0)) u_si  (.clk(clk), .nrst(nrst), .d(link.si),   .q(si_q));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {cs_d, sck_d} <= {1'b1, 1'b0};
      end else begin
         {cs_d, sck_d} <= {cs_q, sck_q};
      end
   end

   wire cs_fall  = cs_d & ~cs_q;
   wire cs_rise  = ~cs_d & cs_q;
   wire sck_rise = ~sck_d & sck_q;

   function automatic logic is_load(input logic [7:0] op);
      is_load = (op == OP_BUF1_WRITE) || (op == OP_BUF2_WRITE) || (op == OP_BUF1_LOAD_EPROG)
             || (op == OP_BUF2_LOAD_EPROG) || (op == OP_BYTE_PROG);
   endfunction

   function automatic logic buf_of(input logic [7:0] op);
      buf_of = (op == OP_BUF2_WRITE) || (op == OP_BUF2_EPROG) || (op == OP_BUF2_PROG)
            || (op == OP_BUF2_LOAD_EPROG);
   endfunction

   // ----------------------------------------------------------------
   // Command receiver
   // ----------------------------------------------------------------
   logic              active, next_active;
   logic [2:0]        bit_cnt, next_bit_cnt;
   logic [2:0]        byte_cnt, next_byte_cnt;
   logic [7:0]        shreg, next_shreg;
   logic [7:0]        opcode, next_opcode;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [OFF_W-1:0]  wr_off, next_wr_off;
   logic              launch, launch_erase, launch_masked;
   logic              op_idle;

   wire       byte_done = active & ~cs_q & sck_rise & (bit_cnt == LAST_BIT);
   wire [7:0] rx_byte   = {shreg[6:0], si_q};
   wire       in_data   = (byte_cnt == HDR_BYTES);
   wire       buf_we    = byte_done & in_data & is_load(opcode);
   wire       mask_clr  = byte_done & (byte_cnt == 3'h3) & (opcode == OP_BYTE_PROG);

   always_comb begin
      {next_active, next_bit_cnt, next_byte_cnt} = {active, bit_cnt, byte_cnt};
      {next_shreg, next_opcode, next_addr, next_wr_off} = {shreg, opcode, addr, wr_off};
      {launch, launch_erase, launch_masked} = 3'b000;
      if (cs_fall) begin
         // Selection while an operation runs is ignored as a whole
         next_active   = op_idle;
         next_bit_cnt  = '0;
         next_byte_cnt = '0;
      end else if (active && cs_rise) begin
         next_active   = 1'b0;
         launch_erase  = in_data && ((opcode == OP_BUF1_EPROG) || (opcode == OP_BUF2_EPROG)
                  || (opcode == OP_BUF1_LOAD_EPROG) || (opcode == OP_BUF2_LOAD_EPROG));
         launch_masked = in_data && (opcode == OP_BYTE_PROG);
         launch        = launch_erase || (launch_masked && (bit_cnt == 3'h0))
                  || (in_data && ((opcode == OP_BUF1_PROG) || (opcode == OP_BUF2_PROG)));
      end else if (active && sck_rise) begin
         next_shreg   = rx_byte;
         next_bit_cnt = bit_cnt + 3'h1;
         if (bit_cnt == LAST_BIT) begin
            if (byte_cnt == 3'h0) begin
               next_opcode = rx_byte;
            end else if (!in_data) begin
               next_addr = {addr[ADDR_W-9:0], rx_byte};
            end
            if (byte_cnt == 3'h3) begin
               next_wr_off = offset_of({addr[ADDR_W-9:0], rx_byte}, binary_page_size);
            end
            if (!in_data) begin
               next_byte_cnt = byte_cnt + 3'h1;
            end else if (is_load(opcode)) begin
               next_wr_off = wrap_inc(wr_off, binary_page_size);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {active, bit_cnt, byte_cnt, shreg, opcode, addr, wr_off} <= '0;
      end else begin
         {active, bit_cnt, byte_cnt} <= {next_active, next_bit_cnt, next_byte_cnt};
         {shreg, opcode, addr, wr_off} <= {next_shreg, next_opcode, next_addr, next_wr_off};
      end
   end

   // ----------------------------------------------------------------
   // Page buffers and received-byte mask
   // ----------------------------------------------------------------
   logic [7:0]           buf_mem [2][BUF_BYTES];
   logic [7:0]           next_buf [2][BUF_BYTES];
   logic [BUF_BYTES-1:0] rx_mask, next_mask;

   always_comb begin
      next_buf  = buf_mem;
      next_mask = rx_mask;
      if (mask_clr) begin
         next_mask = '0;
      end
      // Offsets above the page end in standard mode are dropped, not aliased
      if (buf_we && (wr_off <= page_last(binary_page_size))) begin
         next_buf[buf_of(opcode)][wr_off] = rx_byte;
         if (opcode == OP_BYTE_PROG) begin
            next_mask[wr_off] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buf_mem <= '{default: '{default: 8'h00}};
         rx_mask <= '0;
      end else begin
         buf_mem <= next_buf;
         rx_mask <= next_mask;
      end
   end

   // ----------------------------------------------------------------
   // Self-timed erase / program sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_IDLE  = 3'b000,
      OP_WRITE = 3'b001,
      OP_CHECK = 3'b011,
      OP_WAIT  = 3'b010,
      OP_NEXT  = 3'b110
   } sfp_op_t;

   sfp_op_t           state, next_state;
   logic              erasing, next_erasing;
   logic              masked, next_masked;
   logic              sel, next_sel;
   logic              err, next_err;
   logic [PAGE_W-1:0] page, next_page;
   logic [OFF_W-1:0]  idx, next_idx;
   logic [15:0]       wait_cnt, next_wait_cnt;
   logic [7:0]        wdata, next_wdata;

   assign op_idle = (state == OP_IDLE);

   always_comb begin
      next_state    = state;
      {next_erasing, next_masked, next_sel, next_err} = {erasing, masked, sel, err};
      {next_page, next_idx, next_wait_cnt} = {page, idx, wait_cnt};
      array_we      = 1'b0;
      case (state)
         OP_IDLE: begin
            if (launch) begin
               next_page    = page_of(addr, binary_page_size);
               next_sel     = buf_of(opcode);
               next_erasing = launch_erase;
               next_masked  = launch_masked;
               next_idx     = '0;
               next_err     = 1'b0;
               next_state   = OP_WRITE;
            end
         end
         OP_WRITE: begin
            // Untouched bytes skip the write, check and wait, costing two cycles each, so duration follows byte count
            if (!erasing && masked && !rx_mask[idx]) begin
               next_state = OP_NEXT;
            end else begin
               array_we   = 1'b1;
               next_state = OP_CHECK;
            end
         end
         OP_CHECK: begin
            if (array_rdata != wdata) begin
               next_err = 1'b1;
            end
            next_wait_cnt = erasing ? 16'(ERASE_STEP_CYCLES - 1) : 16'(BYTE_PROG_CYCLES - 1);
            next_state    = OP_WAIT;
         end
         OP_WAIT: begin
            if (wait_cnt == 16'h0000) begin
               next_state = OP_NEXT;
            end else begin
               next_wait_cnt = wait_cnt - 16'h0001;
            end
         end
         OP_NEXT: begin
            if (idx != page_last(binary_page_size)) begin
               next_idx   = idx + 9'h001;
               next_state = OP_WRITE;
            end else if (erasing) begin
               next_erasing = 1'b0;
               next_idx     = '0;
               next_state   = OP_WRITE;
            end else begin
               next_state = OP_IDLE;
            end
         end
         default: begin
            next_state = OP_IDLE;
         end
      endcase
      next_wdata = next_erasing ? ERASED_BYTE : buf_mem[next_sel][next_idx];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= OP_IDLE;
         {erasing, masked, sel, err, page, idx, wait_cnt, wdata} <= '0;
      end else begin
         state <= next_state;
         {erasing, masked, sel, err} <= {next_erasing, next_masked, next_sel, next_err};
         {page, idx, wait_cnt, wdata} <= {next_page, next_idx, next_wait_cnt, next_wdata};
      end
   end

   assign busy                     = ~op_idle;
   assign erase_program_error_flag = err;
   assign array_page               = page;
   assign array_offset             = idx;
   assign array_wdata              = wdata;
endmodule

//--- hdl/sfp_host.sv
// Host end: frames one program command per request on the serial link
// Assumes the user waits for the device to go idle before the next command
`timescale 1ns/1ps
module sfp_host
   import sfp_pkg::*;
#(
   parameter int SCK_HALF = SCK_HALF_CYC
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   sfp_if.host                    link,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire logic [7:0]        cmd_opcode,
   input  wire logic [PAGE_W-1:0] cmd_page,
   input  wire logic [OFF_W-1:0]  cmd_offset,
   input  wire logic              cmd_binary,
   input  wire logic [8:0]        cmd_len,
   input  wire logic [7:0]        data_byte,
   output logic                   data_take
);
   // ----------------------------------------------------------------
   // Framing state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      H_IDLE  = 3'b000,
      H_LEAD  = 3'b001,
      H_LOW   = 3'b011,
      H_HIGH  = 3'b010,
      H_TRAIL = 3'b110
   } sfp_host_t;

   sfp_host_t   state, next_state;
   logic [31:0] hdr, next_hdr;
   logic [9:0]  total, next_total;
   logic [9:0]  byte_idx, next_byte_idx;
   logic [7:0]  sh, next_sh;
   logic [2:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  half, next_half;
   logic        cs_n, next_cs_n;
   logic        sck, next_sck;
   logic        si, next_si;

   always_comb begin
      next_state    = state;
      next_hdr      = hdr;
      next_total    = total;
      next_byte_idx = byte_idx;
      next_sh       = sh;
      next_bit_cnt  = bit_cnt;
      next_half     = (half == 8'h00) ? 8'h00 : half - 8'h01;
      next_cs_n     = cs_n;
      next_sck      = sck;
      next_si       = si;
      data_take     = 1'b0;
      case (state)
         H_IDLE: begin
            if (cmd_valid && half == 8'h00) begin
               next_hdr   = {cmd_opcode, build_addr(cmd_page, cmd_offset, cmd_binary)};
               next_total = {1'b0, cmd_len} + 10'h004;
               next_byte_idx = '0;
               next_cs_n  = 1'b0;
               next_half  = 8'(SCK_HALF - 1);
               next_state = H_LEAD;
            end
         end
         H_HIGH, H_LEAD: begin
            if (half == 8'h00) begin
               next_half = 8'(SCK_HALF - 1);
               next_sck  = 1'b0;
               next_state = H_LOW;
               if (state == H_HIGH && bit_cnt != LAST_BIT) begin
                  next_sh      = {sh[6:0], 1'b0};
                  next_si      = sh[6];
                  next_bit_cnt = bit_cnt + 3'h1;
               end else begin
                  if (state == H_HIGH) begin
                     next_byte_idx = byte_idx + 10'h001;
                  end
                  // Whole bytes only, so the device never sees a torn frame
                  if (next_byte_idx == total) begin
                     next_state = H_TRAIL;
                  end else if (next_byte_idx < {7'h00, HDR_BYTES}) begin
                     next_sh      = hdr[31:24];
                     next_hdr     = {hdr[23:0], 8'h00};
                     next_si      = hdr[31];
                     next_bit_cnt = '0;
                  end else begin
                     data_take    = 1'b1;
                     next_sh      = data_byte;
                     next_si      = data_byte[7];
                     next_bit_cnt = '0;
                  end
               end
            end
         end
         H_LOW: begin
            if (half == 8'h00) begin
               next_half  = 8'(SCK_HALF - 1);
               next_sck   = 1'b1;
               next_state = H_HIGH;
            end
         end
         H_TRAIL: begin
            if (half == 8'h00) begin
               next_cs_n  = 1'b1;
               next_half  = 8'(SCK_HALF - 1);
               next_state = H_IDLE;
            end
         end
         default: begin
            next_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= H_IDLE;
         hdr      <= '0;
         total    <= '0;
         byte_idx <= '0;
         sh       <= '0;
         bit_cnt  <= '0;
         half     <= '0;
         cs_n     <= 1'b1;
         sck      <= 1'b0;
         si       <= 1'b0;
      end else begin
         state    <= next_state;
         hdr      <= next_hdr;
         total    <= next_total;
         byte_idx <= next_byte_idx;
         sh       <= next_sh;
         bit_cnt  <= next_bit_cnt;
         half     <= next_half;
         cs_n     <= next_cs_n;
         sck      <= next_sck;
         si       <= next_si;
      end
   end

   assign cmd_ready = (state == H_IDLE) && (half == 8'h00);
   assign link.cs_n = cs_n;
   assign link.sck  = sck;
   assign link.si   = si;
endmodule

//--- tb/sfp_assertions.sv
// Checker on the serial link and device status
// Assumes host SCK_HALF of 8 cycles
`timescale 1ns/1ps
module sfp_assertions
   import sfp_pkg::*;
(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              cs_n,
   input wire logic              sck,
   input wire logic              si,
   input wire logic              busy,
   input wire logic              erase_program_error_flag,
   input wire logic              array_we,
   input wire logic [PAGE_W-1:0] array_page
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
      else $error("sck moves while deselected");
   a_si_held_high: assert property (sck && $past(sck) |-> $stable(si))
      else $error("si changes while sck high");
   a_sck_high_len: assert property ($rose(sck) |-> sck [*8])
      else $error("sck high phase short");
   a_select_lead: assert property ($fell(cs_n) |-> !sck [*8])
      else $error("sck rises too soon after select");
   a_deselect_gap: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("deselect gap short");
   a_write_in_busy: assert property (array_we |-> busy)
      else $error("array write outside busy");
   a_page_held: assert property (busy && $past(busy) |-> $stable(array_page))
      else $error("page moves during operation");
   a_busy_floor: assert property ($rose(busy) |-> busy [*4])
      else $error("busy too short");
   a_error_cleared: assert property ($rose(busy) |=> !erase_program_error_flag)
      else $error("error flag not cleared at launch");
endmodule

//--- tb/test_serial_flash_program_commands.sv
// Bench joining host and device over the serial link
// Assumes a main array modelled here; stuck inverts its read data
`timescale 1ns/1ps
module test_serial_flash_program_commands;
   import sfp_pkg::*;
   // ----------------------------------------
   // Stimulus, array model and checks
   // ----------------------------------------
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              vld = 1'b0;
   logic              bin = 1'b0;
   logic              stuck = 1'b0;
   logic [7:0]        opc = 8'h00;
   logic [10:0]       cpg = 11'h000;
   logic [8:0]        cof = 9'h000;
   logic [8:0]        len = 9'h000;
   logic [7:0]        k = 8'h00;
   logic              rdy, take, busy, err, we;
   logic [PAGE_W-1:0] pg;
   logic [OFF_W-1:0]  of;
   logic [7:0]        wd;
   logic [7:0]        mem [0:2047];
   int                n_errors = 0;
   int                total_checks = 0;
   wire [10:0]        idx = {pg[1:0], of};
   sfp_if sfp_if_inst ();
   always #5 clk = ~clk;
   // Write-through array keeps verify reads exact
   always @(posedge clk) if (we) mem[idx] <= wd;
   // Data counter restarts with each request, so every frame sends c0 first
   always @(posedge clk)
      if (vld) k <= 8'h00;
      else if (take) k <= k + 8'h01;
   sfp_host #(.SCK_HALF(8)) sfp_host_inst (.clk(clk), .nrst(nrst), .link(sfp_if_inst),
      .cmd_valid(vld), .cmd_ready(rdy), .cmd_opcode(opc), .cmd_page(cpg), .cmd_offset(cof),
      .cmd_binary(bin), .cmd_len(len), .data_byte(8'hc0 + k), .data_take(take));
   sfp_device #(.BYTE_PROG_CYCLES(1), .ERASE_STEP_CYCLES(1)) sfp_device_inst (.clk(clk),
      .nrst(nrst), .link(sfp_if_inst), .binary_page_size(bin), .busy(busy),
      .erase_program_error_flag(err), .array_we(we), .array_page(pg), .array_offset(of),
      .array_wdata(wd), .array_rdata(stuck ? ~mem[idx] : mem[idx]));
   sfp_assertions sfp_assertions_inst (.clk(clk), .nrst(nrst), .cs_n(sfp_if_inst.cs_n),
      .sck(sfp_if_inst.sck), .si(sfp_if_inst.si), .busy(busy),
      .erase_program_error_flag(err), .array_we(we), .array_page(pg));
   task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic send(input logic [7:0] o, input logic [10:0] p, input logic [8:0] f,
                       input logic [8:0] n);
      int t;
      @(posedge clk);
      opc <= o;
      cpg <= p;
      cof <= f;
      len <= n;
      vld <= 1'b1;
      @(negedge clk);
      while (rdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      vld <= 1'b0;
      @(posedge sfp_if_inst.cs_n);
      // Busy rises a few cycles after the synced deselect
      repeat (10) @(posedge clk);
      chk("busy", {7'h00, busy}, 8'(o != OP_BUF1_WRITE && o != OP_BUF2_WRITE));
      for (t = 0; busy !== 1'b0 && t < 9000; t++) @(posedge clk);
      if (t == 9000) n_errors++;
   endtask
   task automatic s_wrap();
      send(OP_BUF1_WRITE, 11'h000, 9'h106, 9'h003);
      send(OP_BUF1_PROG, 11'h001, 9'h000, 9'h000);
      chk("wrap end", mem[11'h306], 8'hc0);
      chk("wrap last", mem[11'h307], 8'hc1);
      chk("wrap zero", mem[11'h200], 8'hc2);
   endtask
   task automatic s_lep();
      bin <= 1'b1;
      send(OP_BUF2_LOAD_EPROG, 11'h002, 9'h0ff, 9'h002);
      chk("bin end", mem[11'h4ff], 8'hc0);
      chk("bin wrap", mem[11'h400], 8'hc1);
      chk("bin err", {7'h00, err}, 8'h00);
      bin <= 1'b0;
   endtask
   task automatic s_byte();
      send(OP_BYTE_PROG, 11'h003, 9'h107, 9'h002);
      chk("byte last", mem[11'h707], 8'hc0);
      chk("byte zero", mem[11'h600], 8'hc1);
      chk("byte kept", mem[11'h601], 8'h33);
   endtask
   task automatic s_err();
      stuck <= 1'b1;
      send(OP_BUF1_EPROG, 11'h000, 9'h000, 9'h000);
      chk("err flag", {7'h00, err}, 8'h01);
      chk("eprog last", mem[11'h107], 8'hc0);
      chk("eprog end", mem[11'h106], 8'hc0);
      stuck <= 1'b0;
   endtask
   task automatic s_buf2();
      bin <= 1'b1;
      send(OP_BUF2_WRITE, 11'h000, 9'h0ff, 9'h003);
      send(OP_BUF2_PROG, 11'h001, 9'h000, 9'h000);
      chk("bin prog end", mem[11'h2ff], 8'hc0);
      chk("bin prog wrap", mem[11'h200], 8'hc1);
      chk("bin prog next", mem[11'h201], 8'hc2);
      chk("bin page edge", mem[11'h306], 8'hc0);
      bin <= 1'b0;
   endtask
   initial begin
      for (int i = 0; i < 2048; i++) mem[i] = 8'h33;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      s_wrap();
      s_lep();
      s_byte();
      s_err();
      s_buf2();
      complete_run();
   end
   // Seven operations need about 12k cycles
   initial begin
      #500_000;
      n_errors++;
      complete_run();
   end
endmodule
